//--- rtl/idio_pkg.sv
// constants and types for the isolated digital i/o port
package idio_pkg;
	// bus commands on c/be during the address phase, and the all-enabled byte enable value for the data phase
	localparam logic [3:0] IDIO_CMD_IO_RD = 4'h2;
	localparam logic [3:0] IDIO_CMD_IO_WR = 4'h3;
	localparam logic [3:0] IDIO_CMD_CFG_RD = 4'hA;
	localparam logic [3:0] IDIO_CMD_CFG_WR = 4'hB;
	localparam logic [3:0] IDIO_BE_FULL_N = 4'h0;
	// configuration space offsets and the type 0 code on ad[1:0]
	localparam logic [7:0] IDIO_CFG_ID = 8'h00;
	localparam logic [7:0] IDIO_CFG_CMD = 8'h04;
	localparam logic [7:0] IDIO_CFG_BAR3 = 8'h18;
	localparam logic [1:0] IDIO_CFG_TYPE0 = 2'h0;
	// i/o space layout: one dword at the base
	localparam logic [31:0] IDIO_BAR_MASK = 32'hFFFFFFFC;
	localparam logic [31:0] IDIO_BAR_IO_FLAG = 32'h00000001;
	localparam logic [31:0] IDIO_BAR_RESET = 32'h00000001;
	localparam int IDIO_CMD_IO_EN_BIT = 0;
	localparam logic [1:0] IDIO_IO_OFFSET = 2'h0;
	// register data layout
	localparam int IDIO_CHANNELS = 16;
	localparam logic [15:0] IDIO_UPPER_ZERO = 16'h0000;
	localparam logic [15:0] IDIO_OUT_RESET = 16'h0000;
	localparam logic [31:0] IDIO_ZERO_WORD = 32'h00000000;
	typedef enum logic [1:0] {
		IDIO_S_IDLE,
		IDIO_S_CLAIM,
		IDIO_S_DATA,
		IDIO_S_TURN
	} idio_state_t;
endpackage

//--- rtl/idio_port.sv
// isolated digital i/o port: bus target, input sampling, output drive, edge interrupts
// Functional notes
// - the i/o base address lives in configuration register 18h, written by firmware.
// - the port answers at exactly one dword of i/o space, inputs and outputs alike.
// - an i/o read returns input channels 0-7 in byte 0 and 8-15 in byte 1.
// - an i/o write with all four byte enables active sets output channels 0-7 from byte 0 and 8-15 from byte 1.
// - a rising edge on input 0 raises the first interrupt, on input 1 the second.
`timescale 1ns/1ps
module idio_port
	import idio_pkg::*;
#(
	parameter logic [31:0] ID_WORD = 32'h00010001 // arbitrary identity value
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic pci_frame_n,
	input wire logic pci_irdy_n,
	input wire logic pci_idsel,
	input wire logic [3:0] pci_cbe_n,
	input wire logic [31:0] pci_ad_in,
	output logic [31:0] pci_ad_out,
	output logic pci_ad_oe,
	output logic pci_devsel_n,
	output logic pci_devsel_oe,
	output logic pci_trdy_n,
	output logic pci_trdy_oe,
	output logic pci_stop_n,
	output logic pci_stop_oe,
	input wire logic [IDIO_CHANNELS-1:0] isolated_input_channel_n,
	output logic [IDIO_CHANNELS-1:0] isolated_output_channel_n,
	output logic first_input_irq,
	output logic second_input_irq
);
	idio_state_t state, next_state;
	logic frame_q;
	logic [IDIO_CHANNELS-1:0] in_s1, in_s2, in_s3;
	logic [31:0] bar, next_bar;
	logic io_en, next_io_en;
	logic [3:0] cmd, next_cmd;
	logic [7:0] cfg_reg, next_cfg_reg;
	logic [31:0] ad_out, next_ad_out;
	logic ad_oe, next_ad_oe;
	logic ctl_oe, next_ctl_oe;
	logic devsel_n, next_devsel_n;
	logic trdy_n, next_trdy_n;
	logic [IDIO_CHANNELS-1:0] out_drv, next_out_drv;
	logic irq0, irq1;
	logic addr_phase, io_hit, cfg_hit, done;

	function automatic logic is_read(input logic [3:0] c);
		return (c == IDIO_CMD_IO_RD) || (c == IDIO_CMD_CFG_RD);
	endfunction

	function automatic logic [31:0] cfg_read(input logic [7:0] a, input logic [31:0] b,
			input logic en);
		unique case (a)
			IDIO_CFG_ID: cfg_read = ID_WORD;
			IDIO_CFG_CMD: cfg_read = {31'h00000000, en};
			IDIO_CFG_BAR3: cfg_read = b;
			default: cfg_read = IDIO_ZERO_WORD;
		endcase
	endfunction

	assign addr_phase = !pci_frame_n && frame_q;
	assign io_hit = addr_phase && io_en && (pci_ad_in[1:0] == IDIO_IO_OFFSET)
		&& ((pci_ad_in & IDIO_BAR_MASK) == (bar & IDIO_BAR_MASK))
		&& ((pci_cbe_n == IDIO_CMD_IO_RD) || (pci_cbe_n == IDIO_CMD_IO_WR));
	assign cfg_hit = addr_phase && pci_idsel && (pci_ad_in[1:0] == IDIO_CFG_TYPE0)
		&& ((pci_cbe_n == IDIO_CMD_CFG_RD) || (pci_cbe_n == IDIO_CMD_CFG_WR));
	assign done = (state == IDIO_S_DATA) && !pci_irdy_n;

	// input pins cross in through two flops
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			in_s1 <= '0;
			in_s2 <= '0;
			in_s3 <= '0;
			frame_q <= 1'b1;
			irq0 <= 1'b0;
			irq1 <= 1'b0;
		end else begin
			in_s1 <= isolated_input_channel_n;
			in_s2 <= in_s1;
			in_s3 <= in_s2;
			frame_q <= pci_frame_n;
			irq0 <= in_s2[0] && !in_s3[0];
			irq1 <= in_s2[1] && !in_s3[1];
		end
	end

	always_comb begin
		next_state = state;
		next_bar = bar;
		next_io_en = io_en;
		next_cmd = cmd;
		next_cfg_reg = cfg_reg;
		next_ad_out = ad_out;
		next_ad_oe = 1'b0;
		next_ctl_oe = 1'b0;
		next_devsel_n = 1'b1;
		next_trdy_n = 1'b1;
		next_out_drv = out_drv;
		unique case (state)
			IDIO_S_IDLE: begin
				if (io_hit || cfg_hit) begin
					next_state = IDIO_S_CLAIM;
					next_cmd = pci_cbe_n;
					next_cfg_reg = {pci_ad_in[7:2], 2'b00};
					next_ctl_oe = 1'b1;
					next_devsel_n = 1'b0;
				end
			end
			IDIO_S_CLAIM: begin
				next_state = IDIO_S_DATA;
				next_ctl_oe = 1'b1;
				next_devsel_n = 1'b0;
				next_trdy_n = 1'b0;
				next_ad_oe = is_read(cmd);
				if (cmd == IDIO_CMD_IO_RD) begin
					next_ad_out = {IDIO_UPPER_ZERO, in_s2};
				end else begin
					next_ad_out = cfg_read(cfg_reg, bar, io_en);
				end
			end
			IDIO_S_DATA: begin
				next_ctl_oe = 1'b1;
				if (done) begin
					next_state = IDIO_S_TURN;
					if (cmd == IDIO_CMD_IO_WR && pci_cbe_n == IDIO_BE_FULL_N) begin
						next_out_drv = pci_ad_in[IDIO_CHANNELS-1:0];
					end
					if (cmd == IDIO_CMD_CFG_WR && cfg_reg == IDIO_CFG_BAR3) begin
						next_bar = (pci_ad_in & IDIO_BAR_MASK) | IDIO_BAR_IO_FLAG;
					end
					if (cmd == IDIO_CMD_CFG_WR && cfg_reg == IDIO_CFG_CMD) begin
						next_io_en = pci_ad_in[IDIO_CMD_IO_EN_BIT];
					end
				end else begin
					next_devsel_n = 1'b0;
					next_trdy_n = 1'b0;
					next_ad_oe = is_read(cmd);
				end
			end
			IDIO_S_TURN: begin
				next_state = IDIO_S_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= IDIO_S_IDLE;
			bar <= IDIO_BAR_RESET;
			io_en <= 1'b0;
			cmd <= IDIO_CMD_IO_RD;
			cfg_reg <= IDIO_CFG_ID;
			ad_out <= IDIO_ZERO_WORD;
			ad_oe <= 1'b0;
			ctl_oe <= 1'b0;
			devsel_n <= 1'b1;
			trdy_n <= 1'b1;
			out_drv <= IDIO_OUT_RESET;
		end else begin
			state <= next_state;
			bar <= next_bar;
			io_en <= next_io_en;
			cmd <= next_cmd;
			cfg_reg <= next_cfg_reg;
			ad_out <= next_ad_out;
			ad_oe <= next_ad_oe;
			ctl_oe <= next_ctl_oe;
			devsel_n <= next_devsel_n;
			trdy_n <= next_trdy_n;
			out_drv <= next_out_drv;
		end
	end

	assign pci_ad_out = ad_out;
	assign pci_ad_oe = ad_oe;
	assign pci_devsel_n = devsel_n;
	assign pci_devsel_oe = ctl_oe;
	assign pci_trdy_n = trdy_n;
	assign pci_trdy_oe = ctl_oe;
	assign pci_stop_n = trdy_n;
	assign pci_stop_oe = ctl_oe;
	assign isolated_output_channel_n = out_drv;
	assign first_input_irq = irq0;
	assign second_input_irq = irq1;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	bar_write_a: assert property (done && cmd == IDIO_CMD_CFG_WR && cfg_reg == IDIO_CFG_BAR3
		|=> bar == (($past(pci_ad_in) & IDIO_BAR_MASK) | IDIO_BAR_IO_FLAG))
		else $error("base register not loaded");
	io_claim_a: assert property (state == IDIO_S_IDLE && io_hit
		|=> !pci_devsel_n ##1 !pci_trdy_n && !pci_devsel_n)
		else $error("matching i/o cycle not claimed");
	io_miss_a: assert property (state == IDIO_S_IDLE && addr_phase && !io_hit && !cfg_hit
		|=> pci_devsel_n [*2])
		else $error("foreign cycle claimed");
	read_value_a: assert property (state == IDIO_S_CLAIM && cmd == IDIO_CMD_IO_RD
		|=> pci_ad_out[15:0] == $past(in_s2) && pci_ad_oe)
		else $error("read data not input state");
	upper_zero_a: assert property (state == IDIO_S_DATA && cmd == IDIO_CMD_IO_RD
		|-> pci_ad_out[31:16] == IDIO_UPPER_ZERO)
		else $error("upper bits not zero");
	write_out_a: assert property (done && cmd == IDIO_CMD_IO_WR && pci_cbe_n == IDIO_BE_FULL_N
		|=> isolated_output_channel_n == $past(pci_ad_in[15:0]))
		else $error("outputs not updated by write");
	read_keeps_a: assert property (done && cmd == IDIO_CMD_IO_RD
		|=> $stable(isolated_output_channel_n))
		else $error("read changed outputs");
	irq_first_a: assert property ($rose(in_s2[0]) |=> first_input_irq ##1 !first_input_irq)
		else $error("first interrupt not raised once");
	irq_second_a: assert property (second_input_irq |-> $past(in_s2[1] && !in_s3[1]))
		else $error("second interrupt without edge");
	data_hold_a: assert property (state == IDIO_S_DATA && $past(state) == IDIO_S_DATA
		|-> $stable(pci_ad_out))
		else $error("read data moved while waiting");

	io_read_c: cover property (done && cmd == IDIO_CMD_IO_RD);
	io_write_c: cover property (done && cmd == IDIO_CMD_IO_WR);
	bar_set_c: cover property (done && cmd == IDIO_CMD_CFG_WR && cfg_reg == IDIO_CFG_BAR3);
	both_irq_c: cover property (first_input_irq && second_input_irq);
endmodule

//--- verif/idio_host.sv
// bus master model issuing configuration and i/o cycles
`timescale 1ns/1ps
module idio_host
	import idio_pkg::*;
(
	input wire logic sys_clk,
	input wire logic [31:0] ad_out,
	input wire logic trdy_n,
	output logic frame_n,
	output logic irdy_n,
	output logic idsel,
	output logic [3:0] cbe_n,
	output logic [31:0] ad
);
	initial begin
		frame_n = 1'b1;
		irdy_n = 1'b1;
		idsel = 1'b0;
		cbe_n = 4'hF;
		ad = 32'h00000000;
	end
	// one single-data-phase transfer, hit low on master abort
	// waits holds master ready off for that many cycles after the address phase
	task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input logic [3:0] be,
			input logic [31:0] wdata, input int waits, output logic [31:0] rdata,
			output logic hit);
		hit = 1'b0;
		@(posedge sys_clk);
		#1;
		frame_n = 1'b0;
		idsel = cmd[3];
		cbe_n = cmd;
		ad = addr;
		@(posedge sys_clk);
		#1;
		frame_n = 1'b1;
		idsel = 1'b0;
		irdy_n = (waits > 0);
		cbe_n = be;
		ad = cmd[0] ? wdata : ~addr;
		for (int n = 0; n < 6 + waits && !hit; n++) begin
			@(posedge sys_clk);
			#1;
			if (n + 1 >= waits) irdy_n = 1'b0;
			hit = (trdy_n === 1'b0) && (irdy_n === 1'b0);
		end
		rdata = hit ? ad_out : 32'hFFFFFFFF;
		if (hit) begin
			@(posedge sys_clk);
			#1;
		end
		irdy_n = 1'b1;
		cbe_n = 4'hF;
		ad = ~ad;
		repeat (3) @(posedge sys_clk);
	endtask
endmodule

//--- verif/idio_port_tb.sv
// self-checking bench for the isolated digital i/o port
`timescale 1ns/1ps
module idio_port_tb
	import idio_pkg::*;
;
	localparam logic [31:0] TB_ID = 32'h00A50011; // arbitrary identity value
	localparam logic [31:0] BASE = 32'h0000E000;
	logic sys_clk, rst, frame_n, irdy_n, idsel;
	logic [3:0] cbe_n;
	logic [31:0] ad, ad_out;
	logic trdy_n;
	logic [15:0] din, dout;
	logic irq1, irq2;
	logic ad_oe, devsel_n, devsel_oe, trdy_oe, stop_n, stop_oe, rd_now;
	int miscompares, comparisons, n1, n2, waits;
	idio_port #(.ID_WORD(TB_ID)) dut_u (.sys_clk(sys_clk), .rst(rst), .pci_frame_n(frame_n),
		.pci_irdy_n(irdy_n), .pci_idsel(idsel), .pci_cbe_n(cbe_n), .pci_ad_in(ad),
		.pci_ad_out(ad_out), .pci_ad_oe(ad_oe), .pci_devsel_n(devsel_n),
		.pci_devsel_oe(devsel_oe), .pci_trdy_n(trdy_n), .pci_trdy_oe(trdy_oe),
		.pci_stop_n(stop_n), .pci_stop_oe(stop_oe),
		.isolated_input_channel_n(din), .isolated_output_channel_n(dout),
		.first_input_irq(irq1), .second_input_irq(irq2));
	idio_host host_u (.sys_clk(sys_clk), .ad_out(ad_out), .trdy_n(trdy_n), .frame_n(frame_n),
		.irdy_n(irdy_n), .idsel(idsel), .cbe_n(cbe_n), .ad(ad));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// pulse counts and target handshake, looked at mid-cycle
	always @(negedge sys_clk) begin
		if (irq1 === 1'b1) n1++;
		if (irq2 === 1'b1) n2++;
		if (trdy_n === 1'b0) begin
			chk({devsel_n, stop_n, ad_oe}, {31'h0, rd_now});
			chk({devsel_oe, trdy_oe, stop_oe}, 32'h00000007);
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic [3:0] cmd, input logic [31:0] addr, input logic [3:0] be,
			input logic [31:0] wdata, input logic exp_hit, input logic [31:0] exp);
		logic [31:0] r;
		logic h;
		rd_now = !cmd[0];
		host_u.xfer(cmd, addr, be, wdata, waits, r, h);
		chk({31'h00000000, h}, {31'h00000000, exp_hit});
		if (!cmd[0] && exp_hit) chk(r, exp);
	endtask
	task automatic set_in(input logic [15:0] v);
		@(posedge sys_clk);
		#1;
		din = v;
		repeat (8) @(posedge sys_clk);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// whole sequence needs well under a thousand cycles
	initial begin
		repeat (2000) @(posedge sys_clk);
		miscompares++;
		report_and_stop();
	end
	initial begin
		rst = 1'b1;
		din = 16'h0000;
		waits = 0;
		rd_now = 1'b0;
		miscompares = 0;
		comparisons = 0;
		repeat (5) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		chk({16'h0000, dout}, 32'h00000000);
		acc(IDIO_CMD_CFG_RD, 32'h00000000, IDIO_BE_FULL_N, 32'h0, 1'b1, TB_ID);
		acc(IDIO_CMD_CFG_RD, 32'h00000018, IDIO_BE_FULL_N, 32'h0, 1'b1, 32'h00000001);
		acc(IDIO_CMD_CFG_WR, 32'h00000018, IDIO_BE_FULL_N, BASE, 1'b1, 32'h0);
		acc(IDIO_CMD_CFG_RD, 32'h00000018, IDIO_BE_FULL_N, 32'h0, 1'b1, BASE | 32'h1);
		acc(IDIO_CMD_CFG_WR, 32'h00000004, IDIO_BE_FULL_N, 32'h1, 1'b1, 32'h0);
		acc(IDIO_CMD_CFG_RD, 32'h00000004, IDIO_BE_FULL_N, 32'h0, 1'b1, 32'h00000001);
		acc(IDIO_CMD_CFG_RD, 32'h00000008, IDIO_BE_FULL_N, 32'h0, 1'b1, 32'h00000000);
		set_in(16'hA5C3);
		acc(IDIO_CMD_IO_RD, BASE, IDIO_BE_FULL_N, 32'h0, 1'b1, 32'h0000A5C3);
		acc(IDIO_CMD_IO_WR, BASE, IDIO_BE_FULL_N, 32'hFFFF5A3C, 1'b1, 32'h0);
		chk({16'h0000, dout}, 32'h00005A3C);
		// master holds ready off: data must stand through the wait
		waits = 2;
		set_in(16'h3C5A);
		acc(IDIO_CMD_IO_RD, BASE, IDIO_BE_FULL_N, 32'h0, 1'b1, 32'h00003C5A);
		acc(IDIO_CMD_IO_WR, BASE, IDIO_BE_FULL_N, 32'h0000C3A5, 1'b1, 32'h0);
		chk({16'h0000, dout}, 32'h0000C3A5);
		waits = 0;
		acc(IDIO_CMD_IO_WR, BASE + 32'h4, IDIO_BE_FULL_N, 32'h0000FFFF, 1'b0, 32'h0);
		acc(IDIO_CMD_IO_RD, BASE + 32'h4, IDIO_BE_FULL_N, 32'h0, 1'b0, 32'h0);
		acc(IDIO_CMD_IO_WR, BASE, 4'hC, 32'h00001111, 1'b1, 32'h0);
		chk({16'h0000, dout}, 32'h0000C3A5);
		// i/o decode off: the base no longer answers
		acc(IDIO_CMD_CFG_WR, 32'h00000004, IDIO_BE_FULL_N, 32'h0, 1'b1, 32'h0);
		acc(IDIO_CMD_IO_RD, BASE, IDIO_BE_FULL_N, 32'h0, 1'b0, 32'h0);
		// reset again mid-run
		@(posedge sys_clk);
		#1;
		rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		chk({16'h0000, dout}, 32'h00000000);
		acc(IDIO_CMD_CFG_RD, 32'h00000018, IDIO_BE_FULL_N, 32'h0, 1'b1, 32'h00000001);
		acc(IDIO_CMD_CFG_RD, 32'h00000004, IDIO_BE_FULL_N, 32'h0, 1'b1, 32'h00000000);
		set_in(16'h0000);
		n1 = 0;
		n2 = 0;
		set_in(16'h0001);
		chk(n1, 1);
		chk(n2, 0);
		set_in(16'h0003);
		chk(n1, 1);
		chk(n2, 1);
		set_in(16'h0000);
		chk(n1 + n2, 2);
		// both channels rise together
		set_in(16'h0003);
		chk(n1, 2);
		chk(n2, 2);
		report_and_stop();
	end
endmodule
